// File: sim/conv_core_model.sv
// converter core model: answers each start lag+1 cycles later
`timescale 1ns/1ps
module conv_core_model (
  // clock
  input wire logic       mclk,
  // bench controls
  input wire logic [9:0] val,
  input wire logic [3:0] lag,
  // sequencer side
  input wire logic       convStart,
  input wire logic       offsetSign,
  output logic           convDone,
  output logic [9:0]     convData
);
  int cnt = -1;
  initial convDone = 1'b0;
  initial convData = 10'h000;
  // data set at start, done rises later and holds until next start
  always @(posedge mclk) begin
    if (convStart) begin
      convDone <= 1'b0;
      convData <= val + {8'h00, offsetSign, 1'b0};
      cnt <= lag;
    end else if (cnt > 0) cnt <= cnt - 1;
    else if (cnt == 0) begin
      convDone <= 1'b1;
      cnt <= -1;
    end
  end
endmodule : conv_core_model

// File: sim/tb_adc_conversion_sequencer.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
  error_cnt++; $display("ERROR %s exp %h got %h", n, e, a); end end
module tb_adc_conversion_sequencer;
  localparam logic [7:0] CTL = adc_seq_pkg::OFS_CTRL;
  localparam logic [7:0] CT2 = adc_seq_pkg::OFS_CTRL2;
  localparam logic [7:0] RES = adc_seq_pkg::OFS_RESULT;
  logic        mclk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [7:0]  regAddr = 8'h00, chanSel;
  logic [31:0] regWdata = 32'h0, regRdata, rdv;
  logic [9:0]  val = 10'h155, convData;
  logic [3:0]  lag = 4'h2, scaleSel;
  logic regulatorEn, converterEn, sampleEn, convStart, offsetSign;
  logic convDone, singleEnded, convIrq, dmaReq;
  int error_cnt = 0, total_checks = 0, nStart = 0, nDma = 0, s, d;
  int nSmp = 0, m;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (convStart) nStart <= nStart + 1;
    if (dmaReq) nDma <= nDma + 1;
    if (sampleEn) nSmp <= nSmp + 1;
  end
  adc_conversion_sequencer #(.TICK_CYCLES(16)) i_adc_conversion_sequencer (
    .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .regulatorEn(regulatorEn),
    .converterEn(converterEn), .sampleEn(sampleEn), .convStart(convStart),
    .offsetSign(offsetSign), .singleEnded(singleEnded), .chanSel(chanSel),
    .scaleSel(scaleSel), .convDone(convDone), .convData(convData),
    .convIrq(convIrq), .dmaReq(dmaReq));
  conv_core_model i_conv_core_model (.mclk(mclk), .val(val), .lag(lag),
    .convStart(convStart), .offsetSign(offsetSign), .convDone(convDone),
    .convData(convData));
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
    @(posedge mclk);
  endtask : rd
  task automatic waitIdle();
    rdv = 32'h2;
    for (int i = 0; i < 300 && rdv[1] !== 1'b0; i++) rd(CTL);
  endtask : waitIdle
  task automatic run(input logic [7:0] c, input int n, input logic [15:0] e);
    s = nStart;
    d = nDma;
    m = nSmp;
    wr(CTL, {24'h0, c | 8'h43});
    waitIdle();
    `CHK("starts", n, nStart - s)
    `CHK("dma", 1, nDma - d)
    `CHK("sampled", 8 * n, nSmp - m)
    rd(RES);
    `CHK("result", e, rdv[15:0])
  endtask : run
  task automatic t_power();
    s = nStart;
    wr(CT2, 32'h0F00);
    wr(CTL, 32'h41);
    @(posedge mclk);
    `CHK("reg", 2'b10, {regulatorEn, converterEn})
    wr(CTL, 32'h43);
    repeat (246) @(posedge mclk);
    `CHK("early", 1'b0, converterEn)
    repeat (10) @(posedge mclk);
    `CHK("enabled", 1'b1, converterEn)
    rd(CTL);
    `CHK("busy", 1'b1, rdv[1])
    wr(CTL, 32'h43);
    waitIdle();
    `CHK("once", 1, nStart - s)
    `CHK("flag", 2'b11, {rdv[2], convIrq})
    rd(RES);
    `CHK("first", 16'h5540, rdv[15:0])
    wr(CTL, 32'h01);
    `CHK("masked", 1'b0, convIrq)
    wr(CTL, 32'h41);
    wr(adc_seq_pkg::OFS_CLEAR, 32'h0);
    `CHK("cleared", 1'b0, convIrq)
    $display("power test done");
  endtask : t_power
  task automatic t_avg();
    wr(CT2, 32'h104);
    run(8'h00, 2, 16'h5540);
    wr(CT2, 32'h100);
    run(8'h10, 2, 16'h5580);
    wr(CT2, 32'h108);
    run(8'h10, 4, 16'h5580);
    val = 10'h0AA;
    wr(CT2, 32'h100);
    run(8'h00, 1, 16'h2A80);
    lag = 4'hF;
    val = 10'h3FF;
    wr(CT2, 32'h20100);
    run(8'h00, 1, 16'h2A80);
    lag = 4'h2;
    $display("average test done");
  endtask : t_avg
  task automatic t_repeat();
    int p;
    val = 10'h0AA;
    wr(CT2, 32'h100);
    d = nDma;
    wr(CTL, 32'h4B);
    for (int i = 0; i < 2000 && nDma - d < 3; i++) @(posedge mclk);
    `CHK("repeats", 1'b1, nDma - d >= 3)
    wr(CTL, 32'h41);
    waitIdle();
    `CHK("stopped", 1'b0, rdv[1])
    d = nDma;
    repeat (100) @(posedge mclk);
    `CHK("quiet", 0, nDma - d)
    rd(RES);
    `CHK("latest", 16'h2A80, rdv[15:0])
    wr(adc_seq_pkg::OFS_CTRL3, 32'h0240);
    wr(CTL, 32'h4B);
    d = nDma;
    for (int i = 0; i < 300 && nDma == d; i++) @(posedge mclk);
    d = nDma;
    p = 0;
    for (int i = 0; i < 300 && nDma == d; i++) begin
      @(posedge mclk);
      p++;
    end
    `CHK("spacing", 1'b1, p > 32 && p <= 56)
    wr(CTL, 32'h41);
    waitIdle();
    `CHK("gap stop", 1'b0, rdv[1])
    $display("repeat test done");
  endtask : t_repeat
  task automatic t_map();
    for (int c = 0; c < 8; c++) begin
      wr(adc_seq_pkg::OFS_SEL, c);
      `CHK("chan", 8'h01 << c, chanSel)
    end
    for (int c = 0; c < 4; c++) begin
      wr(CT2, 32'h100 | c);
      `CHK("scale", 4'h1 << c, scaleSel)
    end
    rd(8'h18);
    `CHK("unmapped", 32'h0, rdv)
    wr(CTL, 32'h61);
    `CHK("single", 1'b1, singleEnded)
    $display("map test done");
  endtask : t_map
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_power();
    t_avg();
    t_repeat();
    t_map();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    test_done();
  end
endmodule : tb_adc_conversion_sequencer

// File: verilog/acc_if.sv
// carrier between sequencer and sample accumulator
`timescale 1ns/1ps
interface acc_if;
  logic                           clr;
  logic                           add;
  logic [adc_seq_pkg::RAW_W-1:0]  din;
  logic [adc_seq_pkg::SUM_W-1:0]  sum;
  modport ctl (output clr, output add, output din, input sum);
  modport acc (input clr, input add, input din, output sum);
endinterface : acc_if

// File: verilog/adc_conversion_sequencer.sv
// converter sequencer: power-up, conversions, averaging, chopping, regs
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module adc_conversion_sequencer #(
  parameter int unsigned TICK_CYCLES = adc_seq_pkg::SPACING_TICK_CYCLES
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // analog core control
  output logic             regulatorEn,
  output logic             converterEn,
  output logic             sampleEn,
  output logic             convStart,
  output logic             offsetSign,
  output logic             singleEnded,
  output logic      [7:0]  chanSel,
  output logic      [3:0]  scaleSel,
  // analog core answer
  input  wire logic        convDone,
  input  wire logic [9:0]  convData,
  // system events
  output logic             convIrq,
  output logic             dmaReq
);
  localparam int unsigned TW = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  // configuration registers
  logic        powerOn_r,  powerOn_nxt;
  logic        repeat_r,   repeat_nxt;
  logic        chop_r,     chop_nxt;
  logic        se_r,       se_nxt;
  logic        irqMask_r,  irqMask_nxt;
  logic [1:0]  scaler_r,   scaler_nxt;
  logic [2:0]  avgExp_r,   avgExp_nxt;
  logic [3:0]  smpWin_r,   smpWin_nxt;
  logic [7:0]  stWait_r,   stWait_nxt;
  logic [7:0]  settle_r,   settle_nxt;
  logic [7:0]  spacing_r,  spacing_nxt;
  logic [2:0]  channel_r,  channel_nxt;
  logic [31:0] rdata_r,    rdata_nxt;
  // sequencer state
  adc_seq_pkg::seq_state_e state_r, state_nxt;
  logic [10:0] cnt_r,      cnt_nxt;
  logic [7:0]  convIdx_r,  convIdx_nxt;
  logic [7:0]  gapCnt_r,   gapCnt_nxt;
  logic [TW-1:0] tickCnt_r, tickCnt_nxt;
  logic        goBit_r,    goBit_nxt;
  logic        flag_r,     flag_nxt;
  logic        finPend_r,  finPend_nxt;
  logic        sign_r,     sign_nxt;
  logic [15:0] result_r,   result_nxt;
  logic [9:0]  lastRaw_r,  lastRaw_nxt;
  logic        dma_r,      dma_nxt;
  logic        regEn_r,    convEn_r,  smp_r,  start_r;
  // synchronisers
  logic        doneS1_r,   doneS2_r,  doneS3_r;
  logic [9:0]  dataS1_r,   dataS2_r;
  // helpers
  logic        ctrlWrite;
  logic        goWrite;
  logic        clearWrite;
  logic        doneRise;
  logic        tick;
  logic        lastConv;
  logic [10:0] cntInc;
  logic [10:0] settleTarget;
  logic [10:0] sampleTarget;
  logic [7:0]  convTotal;
  logic [2:0]  avgShift;
  logic [22:0] avgWide;
  acc_if       accBus ();

  assign ctrlWrite  = regWr && (regAddr == adc_seq_pkg::OFS_CTRL);
  assign goWrite    = ctrlWrite && regWdata[adc_seq_pkg::BIT_GO];
  assign clearWrite = regWr && (regAddr == adc_seq_pkg::OFS_CLEAR);
  assign doneRise   = doneS2_r && !doneS3_r;
  assign tick       = (tickCnt_r == TW'(TICK_CYCLES - 1));
  assign cntInc     = cnt_r + 11'h001;
  assign settleTarget = {1'b0, settle_r, 2'b00};
  assign sampleTarget = {4'h0, smpWin_r, 3'h0};
  // chopping forces at least two conversions
  assign convTotal  = (chop_r && avgExp_r == 3'h0) ? 8'h02 :
                      (8'h01 << avgExp_r);
  assign avgShift   = (chop_r && avgExp_r == 3'h0) ? 3'h1 : avgExp_r;
  assign lastConv   = (convIdx_r == convTotal - 8'h01);
  assign avgWide    = {accBus.sum, 6'h00} >> avgShift;

  // accumulator hookup
  assign accBus.clr = finPend_r || (state_r == adc_seq_pkg::ST_OFF) ||
                      (state_r == adc_seq_pkg::ST_SETTLE) ||
                      (state_r == adc_seq_pkg::ST_IDLE) ||
                      (state_r == adc_seq_pkg::ST_ALIGN);
  assign accBus.add = (state_r == adc_seq_pkg::ST_STORE);
  assign accBus.din = lastRaw_r;

  sample_accumulator u_acc (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .accPort (accBus)
  );

  // register file
  always_comb begin
    powerOn_nxt = powerOn_r;
    repeat_nxt  = repeat_r;
    chop_nxt    = chop_r;
    se_nxt      = se_r;
    irqMask_nxt = irqMask_r;
    scaler_nxt  = scaler_r;
    avgExp_nxt  = avgExp_r;
    smpWin_nxt  = smpWin_r;
    stWait_nxt  = stWait_r;
    settle_nxt  = settle_r;
    spacing_nxt = spacing_r;
    channel_nxt = channel_r;
    rdata_nxt   = 32'h0000_0000;
    if (ctrlWrite) begin
      powerOn_nxt = regWdata[adc_seq_pkg::BIT_POWER_ON];
      repeat_nxt  = regWdata[adc_seq_pkg::BIT_REPEAT];
      chop_nxt    = regWdata[adc_seq_pkg::BIT_CHOP];
      se_nxt      = regWdata[adc_seq_pkg::BIT_SE];
      irqMask_nxt = regWdata[adc_seq_pkg::BIT_IRQ_MASK];
    end
    if (regWr && regAddr == adc_seq_pkg::OFS_CTRL2) begin
      scaler_nxt = regWdata[adc_seq_pkg::POS_SCALER +: 2];
      avgExp_nxt = regWdata[adc_seq_pkg::POS_AVGEXP +: 3];
      smpWin_nxt = regWdata[adc_seq_pkg::POS_SMPWIN +: 4];
      stWait_nxt = regWdata[adc_seq_pkg::POS_STWAIT +: 8];
    end
    if (regWr && regAddr == adc_seq_pkg::OFS_CTRL3) begin
      settle_nxt  = regWdata[adc_seq_pkg::POS_SETTLE +: 8];
      spacing_nxt = regWdata[adc_seq_pkg::POS_SPACING +: 8];
    end
    if (regWr && regAddr == adc_seq_pkg::OFS_SEL) begin
      channel_nxt = regWdata[2:0];
    end
    if (regRd) begin
      case (regAddr)
        adc_seq_pkg::OFS_CTRL: begin
          rdata_nxt[adc_seq_pkg::BIT_POWER_ON] = powerOn_r;
          rdata_nxt[adc_seq_pkg::BIT_GO]       = goBit_r;
          rdata_nxt[adc_seq_pkg::BIT_DONE]     = flag_r;
          rdata_nxt[adc_seq_pkg::BIT_REPEAT]   = repeat_r;
          rdata_nxt[adc_seq_pkg::BIT_CHOP]     = chop_r;
          rdata_nxt[adc_seq_pkg::BIT_SE]       = se_r;
          rdata_nxt[adc_seq_pkg::BIT_IRQ_MASK] = irqMask_r;
          rdata_nxt[adc_seq_pkg::BIT_SIGN]     = sign_r;
        end
        adc_seq_pkg::OFS_CTRL2: begin
          rdata_nxt[adc_seq_pkg::POS_SCALER +: 2] = scaler_r;
          rdata_nxt[adc_seq_pkg::POS_AVGEXP +: 3] = avgExp_r;
          rdata_nxt[adc_seq_pkg::POS_SMPWIN +: 4] = smpWin_r;
          rdata_nxt[adc_seq_pkg::POS_STWAIT +: 8] = stWait_r;
        end
        adc_seq_pkg::OFS_CTRL3: begin
          rdata_nxt[adc_seq_pkg::POS_SETTLE +: 8]  = settle_r;
          rdata_nxt[adc_seq_pkg::POS_SPACING +: 8] = spacing_r;
        end
        adc_seq_pkg::OFS_SEL:    rdata_nxt[2:0]  = channel_r;
        adc_seq_pkg::OFS_RESULT: rdata_nxt[15:0] = result_r;
        default:                 rdata_nxt       = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      powerOn_r <= 1'b0;
      repeat_r  <= 1'b0;
      chop_r    <= 1'b0;
      se_r      <= 1'b0;
      irqMask_r <= 1'b0;
      scaler_r  <= 2'h0;
      avgExp_r  <= 3'h0;
      smpWin_r  <= adc_seq_pkg::SMPWIN_RESET;
      stWait_r  <= adc_seq_pkg::STWAIT_RESET;
      settle_r  <= adc_seq_pkg::SETTLE_RESET;
      spacing_r <= adc_seq_pkg::SPACING_RESET;
      channel_r <= 3'h0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      powerOn_r <= powerOn_nxt;
      repeat_r  <= repeat_nxt;
      chop_r    <= chop_nxt;
      se_r      <= se_nxt;
      irqMask_r <= irqMask_nxt;
      scaler_r  <= scaler_nxt;
      avgExp_r  <= avgExp_nxt;
      smpWin_r  <= smpWin_nxt;
      stWait_r  <= stWait_nxt;
      settle_r  <= settle_nxt;
      spacing_r <= spacing_nxt;
      channel_r <= channel_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // core answer synchronisers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      doneS1_r <= 1'b0;
      doneS2_r <= 1'b0;
      doneS3_r <= 1'b0;
      dataS1_r <= 10'h000;
      dataS2_r <= 10'h000;
    end else begin
      doneS1_r <= convDone;
      doneS2_r <= doneS1_r;
      doneS3_r <= doneS2_r;
      dataS1_r <= convData;
      dataS2_r <= dataS1_r;
    end
  end

  // sequencer
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cntInc;
    convIdx_nxt = convIdx_r;
    gapCnt_nxt  = gapCnt_r;
    tickCnt_nxt = tick ? '0 : tickCnt_r + TW'(1);
    goBit_nxt   = goBit_r;
    flag_nxt    = flag_r;
    finPend_nxt = 1'b0;
    sign_nxt    = sign_r;
    result_nxt  = result_r;
    lastRaw_nxt = doneRise ? dataS2_r : lastRaw_r;
    dma_nxt     = finPend_r;
    if (clearWrite) begin
      flag_nxt = 1'b0;
    end
    if (finPend_r) begin
      flag_nxt   = 1'b1;
      result_nxt = avgWide[15:0];
    end
    // go write accepted only while the go bit is clear and power is on
    if (goWrite && !goBit_r && powerOn_r) begin
      goBit_nxt = 1'b1;
    end
    case (state_r)
      adc_seq_pkg::ST_OFF: begin
        if (powerOn_r) begin
          state_nxt = adc_seq_pkg::ST_SETTLE;
          cnt_nxt   = 11'h000;
        end
      end
      adc_seq_pkg::ST_SETTLE: begin
        if (cntInc >= settleTarget) begin
          state_nxt = adc_seq_pkg::ST_IDLE;
        end
      end
      adc_seq_pkg::ST_IDLE: begin
        cnt_nxt     = 11'h000;
        convIdx_nxt = 8'h00;
        sign_nxt    = 1'b0;
        if (finPend_r) begin
          goBit_nxt = 1'b0;
        end else if (goBit_r) begin
          state_nxt = (spacing_r != 8'h00) ? adc_seq_pkg::ST_ALIGN :
                      adc_seq_pkg::ST_SAMPLE;
        end
      end
      adc_seq_pkg::ST_ALIGN: begin
        cnt_nxt = 11'h000;
        if (tick) begin
          state_nxt = adc_seq_pkg::ST_SAMPLE;
        end
      end
      adc_seq_pkg::ST_GAP: begin
        cnt_nxt = 11'h000;
        if (!repeat_r) begin
          state_nxt = adc_seq_pkg::ST_IDLE;
          goBit_nxt = 1'b0;
        end else if (tick) begin
          gapCnt_nxt = gapCnt_r + 8'h01;
          if (gapCnt_r + 8'h01 == spacing_r) begin
            state_nxt = adc_seq_pkg::ST_SAMPLE;
          end
        end
      end
      adc_seq_pkg::ST_SAMPLE: begin
        if (cntInc >= sampleTarget) begin
          state_nxt = adc_seq_pkg::ST_CONVERT;
          cnt_nxt   = 11'h000;
        end
      end
      adc_seq_pkg::ST_CONVERT: begin
        if (stWait_r == 8'h00) begin
          if (doneRise) begin
            state_nxt = adc_seq_pkg::ST_STORE;
          end
        end else if (cnt_r == {3'h0, stWait_r}) begin
          state_nxt = adc_seq_pkg::ST_STORE;
        end
      end
      adc_seq_pkg::ST_STORE: begin
        cnt_nxt     = 11'h000;
        convIdx_nxt = convIdx_r + 8'h01;
        state_nxt   = adc_seq_pkg::ST_SAMPLE;
        sign_nxt    = chop_r ? !sign_r : 1'b0;
        if (lastConv) begin
          finPend_nxt = 1'b1;
          convIdx_nxt = 8'h00;
          sign_nxt    = 1'b0;
          gapCnt_nxt  = 8'h00;
          if (!repeat_r) begin
            state_nxt = adc_seq_pkg::ST_IDLE;
          end else if (spacing_r != 8'h00) begin
            state_nxt = adc_seq_pkg::ST_GAP;
          end else begin
            state_nxt = adc_seq_pkg::ST_SAMPLE;
          end
        end
      end
      default: state_nxt = adc_seq_pkg::ST_OFF;
    endcase
    if (!powerOn_r) begin
      state_nxt = adc_seq_pkg::ST_OFF;
      goBit_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r   <= adc_seq_pkg::ST_OFF;
      cnt_r     <= 11'h000;
      convIdx_r <= 8'h00;
      gapCnt_r  <= 8'h00;
      tickCnt_r <= '0;
      goBit_r   <= 1'b0;
      flag_r    <= 1'b0;
      finPend_r <= 1'b0;
      sign_r    <= 1'b0;
      result_r  <= 16'h0000;
      lastRaw_r <= 10'h000;
      dma_r     <= 1'b0;
      regEn_r   <= 1'b0;
      convEn_r  <= 1'b0;
      smp_r     <= 1'b0;
      start_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      convIdx_r <= convIdx_nxt;
      gapCnt_r  <= gapCnt_nxt;
      tickCnt_r <= tickCnt_nxt;
      goBit_r   <= goBit_nxt;
      flag_r    <= flag_nxt;
      finPend_r <= finPend_nxt;
      sign_r    <= sign_nxt;
      result_r  <= result_nxt;
      lastRaw_r <= lastRaw_nxt;
      dma_r     <= dma_nxt;
      regEn_r   <= (state_nxt != adc_seq_pkg::ST_OFF);
      convEn_r  <= (state_nxt != adc_seq_pkg::ST_OFF) &&
                   (state_nxt != adc_seq_pkg::ST_SETTLE);
      smp_r     <= (state_nxt == adc_seq_pkg::ST_SAMPLE);
      start_r   <= (state_r == adc_seq_pkg::ST_SAMPLE) &&
                   (state_nxt == adc_seq_pkg::ST_CONVERT);
    end
  end

  // outputs
  assign regRdata    = rdata_r;
  assign regulatorEn = regEn_r;
  assign converterEn = convEn_r;
  assign sampleEn    = smp_r;
  assign convStart   = start_r;
  assign offsetSign  = sign_r;
  assign singleEnded = se_r;
  assign chanSel     = 8'h01 << channel_r;
  assign scaleSel    = 4'h1 << scaler_r;
  assign convIrq     = flag_r && irqMask_r;
  assign dmaReq      = dma_r;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_enable_order;
    converterEn |-> regulatorEn;
  endproperty
  a_enable_order: assert property (p_enable_order)
    else $error("converter enabled without regulator");

  property p_go_busy;
    (state_r inside {adc_seq_pkg::ST_SAMPLE, adc_seq_pkg::ST_CONVERT,
                     adc_seq_pkg::ST_STORE}) |-> goBit_r;
  endproperty
  a_go_busy: assert property (p_go_busy)
    else $error("go low during conversion");

  property p_finish;
    (state_r == adc_seq_pkg::ST_STORE && lastConv && !repeat_r &&
     powerOn_r) |=> ##1 (!goBit_r && flag_r && dmaReq);
  endproperty
  a_finish: assert property (p_finish)
    else $error("finish did not clear go and set flag");

  property p_ignore_go;
    (state_r == adc_seq_pkg::ST_SAMPLE && goWrite && powerOn_r) |=>
      (state_r == adc_seq_pkg::ST_CONVERT ||
       cnt_r == $past(cnt_r) + 11'h001) &&
      (convIdx_r == $past(convIdx_r));
  endproperty
  a_ignore_go: assert property (p_ignore_go)
    else $error("go write disturbed running conversion");

  property p_sample_len;
    (state_r != adc_seq_pkg::ST_SAMPLE ##1
     (state_r == adc_seq_pkg::ST_SAMPLE && smpWin_r == 4'h1 && powerOn_r))
    |-> (state_r == adc_seq_pkg::ST_SAMPLE)[*8] ##1
        (state_r != adc_seq_pkg::ST_SAMPLE);
  endproperty
  a_sample_len: assert property (p_sample_len)
    else $error("sampling phase length wrong");

  property p_handshake;
    (state_r == adc_seq_pkg::ST_CONVERT && stWait_r == 8'h00 &&
     doneRise && powerOn_r) |=> (state_r == adc_seq_pkg::ST_STORE);
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("no store after done");

  property p_fixed_wait;
    ($rose(state_r == adc_seq_pkg::ST_CONVERT) && stWait_r == 8'h02 &&
     powerOn_r) |-> (state_r == adc_seq_pkg::ST_CONVERT)[*3] ##1
                    (state_r == adc_seq_pkg::ST_STORE);
  endproperty
  a_fixed_wait: assert property (p_fixed_wait)
    else $error("fixed store delay wrong");

  property p_chop_sign;
    (state_r == adc_seq_pkg::ST_STORE && chop_r && !lastConv &&
     powerOn_r) |=> (offsetSign != $past(offsetSign));
  endproperty
  a_chop_sign: assert property (p_chop_sign)
    else $error("offset sign did not flip");

  property p_clear_flag;
    (clearWrite && !finPend_r) |=> !flag_r && !convIrq;
  endproperty
  a_clear_flag: assert property (p_clear_flag)
    else $error("clear did not drop flag");

  property p_restart;
    (state_r == adc_seq_pkg::ST_STORE && lastConv && repeat_r &&
     spacing_r == 8'h00 && powerOn_r) |=>
      (state_r == adc_seq_pkg::ST_SAMPLE) ##1 dmaReq;
  endproperty
  a_restart: assert property (p_restart)
    else $error("repeat did not restart at once");

  c_finish: cover property (finPend_r && !repeat_r);
  c_repeat: cover property (finPend_r && repeat_r);
  c_chop:   cover property (finPend_r && chop_r && avgExp_r != 3'h0);
  c_fixed:  cover property (state_r == adc_seq_pkg::ST_STORE &&
                            stWait_r != 8'h00);
endmodule : adc_conversion_sequencer

// File: verilog/adc_seq_pkg.sv
// shared constants and types for the conversion sequencer
package adc_seq_pkg;
  // timing
  localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
  localparam int unsigned SPACING_UNIT_NS = 1_024_000;
  localparam int unsigned SPACING_TICK_CYCLES =
    (SPACING_UNIT_NS / 1000) * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned SETTLE_UNIT_CYCLES = 4;
  localparam int unsigned SAMPLE_UNIT_CYCLES = 8;

  // widths
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned RAW_W    = 10;
  localparam int unsigned SUM_W    = 17;
  localparam int unsigned RESULT_W = 16;
  localparam int unsigned CNT_W    = 11;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CTRL2  = 8'h04;
  localparam logic [7:0] OFS_CTRL3  = 8'h08;
  localparam logic [7:0] OFS_SEL    = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_CLEAR  = 8'h14;

  // control word bits
  localparam int unsigned BIT_POWER_ON = 0;
  localparam int unsigned BIT_GO       = 1;
  localparam int unsigned BIT_DONE     = 2;
  localparam int unsigned BIT_REPEAT   = 3;
  localparam int unsigned BIT_CHOP     = 4;
  localparam int unsigned BIT_SE       = 5;
  localparam int unsigned BIT_IRQ_MASK = 6;
  localparam int unsigned BIT_SIGN     = 7;

  // second control word fields
  localparam int unsigned POS_SCALER = 0;
  localparam int unsigned POS_AVGEXP = 2;
  localparam int unsigned POS_SMPWIN = 8;
  localparam int unsigned POS_STWAIT = 16;

  // third control word fields
  localparam int unsigned POS_SETTLE  = 0;
  localparam int unsigned POS_SPACING = 8;

  // reset values
  localparam logic [7:0] SETTLE_RESET  = 8'h40;
  localparam logic [3:0] SMPWIN_RESET  = 4'h1;
  localparam logic [7:0] STWAIT_RESET  = 8'h00;
  localparam logic [7:0] SPACING_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_SETTLE  = 3'b001,
    ST_IDLE    = 3'b010,
    ST_ALIGN   = 3'b011,
    ST_GAP     = 3'b100,
    ST_SAMPLE  = 3'b101,
    ST_CONVERT = 3'b110,
    ST_STORE   = 3'b111
  } seq_state_e;
endpackage : adc_seq_pkg

// File: verilog/sample_accumulator.sv
// running sum of converter samples for averaging
`timescale 1ns/1ps
module sample_accumulator (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // sequencer side
  acc_if.acc       accPort
);
  logic [adc_seq_pkg::SUM_W-1:0] sum_r;
  logic [adc_seq_pkg::SUM_W-1:0] sum_nxt;

  always_comb begin
    sum_nxt = sum_r;
    if (accPort.clr) begin
      sum_nxt = '0;
    end else if (accPort.add) begin
      sum_nxt = sum_r + {{(adc_seq_pkg::SUM_W-adc_seq_pkg::RAW_W){1'b0}},
                         accPort.din};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sum_r <= '0;
    end else begin
      sum_r <= sum_nxt;
    end
  end

  assign accPort.sum = sum_r;
endmodule : sample_accumulator
